// *** test/cfu_mem_model.sv ***
`timescale 1ns/1ps
module cfu_mem_model (
  input  logic                  i_clk_sys,
  input  logic                  i_mem_valid,
  input  cfu_pkg::cfu_mem_req_t i_mem,
  input  logic [3:0]            i_delay,
  output logic                  o_mem_ack,
  output logic [31:0]           o_mem_rdata
);
  import cfu_pkg::*;
  // ==========================================================
  // word memory, acks after i_delay idle cycles
  logic [31:0] mem_q [0:15];
  logic [3:0]  wait_q;
  initial begin
    o_mem_ack = 1'b0;
    o_mem_rdata = 32'h0000_0000;
    wait_q = 4'h0;
    for (int k = 0; k < 16; k++) mem_q[k] = 32'h0000_0000;
  end
  always @(posedge i_clk_sys) begin
    o_mem_ack <= 1'b0;
    // data is only meaningful with ack, so never leave the last word standing
    o_mem_rdata <= ~o_mem_rdata;
    if (i_mem_valid && !o_mem_ack) begin
      if (wait_q == i_delay) begin
        o_mem_ack <= 1'b1;
        wait_q <= 4'h0;
        o_mem_rdata <= mem_q[i_mem.addr[5:2]];
        for (int b = 0; b < 4; b++)
          if (i_mem.we && i_mem.be[b]) mem_q[i_mem.addr[5:2]][8*b+:8] <= i_mem.wdata[8*b+:8];
      end else begin
        wait_q <= wait_q + 4'h1;
      end
    end
  end
endmodule

// *** test/cond_flags_rotate_ldst_unit_tb.sv ***
`timescale 1ns/1ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin miscompares++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, a, b); end end
module cond_flags_rotate_ldst_unit_tb;
  import cfu_pkg::*;
  localparam logic [31:0] SRC = 32'h8000_00A5;
  logic         clk, arst_n, rd_q, wr_q, waitreq, mem_valid, mem_ack, fault;
  logic [7:0]   adr;
  logic [31:0]  wdat, rdat, mem_rdata, q, prev, e;
  logic [3:0]   flags, mdly;
  cfu_mem_req_t mem, last;
  int           miscompares, tests_run, cyc, nflt, nacc, k;
  int           rl [6] = '{1, 4, 31, 32, 33, 36};
  cfu_top i_cfu_top (.i_clk_sys(clk), .i_arst_n(arst_n), .i_avs_address(adr),
    .i_avs_read(rd_q), .i_avs_write(wr_q), .i_avs_writedata(wdat), .i_avs_byteenable(4'hF),
    .o_avs_readdata(rdat), .o_avs_waitrequest(waitreq), .o_mem_valid(mem_valid), .o_mem(mem),
    .i_mem_ack(mem_ack), .i_mem_rdata(mem_rdata), .o_fatal_fault(fault), .o_flags(flags));
  cfu_mem_model i_cfu_mem_model (.i_clk_sys(clk), .i_mem_valid(mem_valid), .i_mem(mem),
    .i_delay(mdly), .o_mem_ack(mem_ack), .o_mem_rdata(mem_rdata));
  // ==========================================================
  // monitors and timeout
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (fault === 1'b1) nflt <= nflt + 1;
    if (mem_valid === 1'b1 && mem_ack === 1'b1) begin
      nacc <= nacc + 1;
      last <= mem;
    end
    if (cyc == 40000) begin
      miscompares++;
      give_verdict();
    end
  end
  // ==========================================================
  // bus and operation tasks
  task automatic give_verdict;
    $display("checks %0d miscompares %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // waits for waitrequest low with no assumed latency
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    adr <= a;
    wdat <= d;
    wr_q <= w;
    rd_q <= !w;
    do begin @(posedge clk); n++; end while (waitreq !== 1'b0 && n < 20);
    q = rdat;
    wr_q <= 1'b0;
    rd_q <= 1'b0;
    @(posedge clk);
    if (n >= 20) miscompares++;
  endtask
  // leaves STATUS in q
  task automatic exec(input logic [31:0] c);
    int n;
    n = 0;
    bus(1'b1, OFS_CTRL, c);
    do begin bus(1'b0, OFS_STATUS, 32'h0000_0000); n++; end
    while (q[STAT_BUSY] !== 1'b0 && n < 30);
  endtask
  function automatic logic cond_ok(input int c, input logic [3:0] f);
    logic n, z, cy, v;
    {n, z, cy, v} = f;
    case (c)
      0: return z;          1: return !z;         2: return cy;   3: return !cy;
      4: return n;          5: return !n;         6: return v;    7: return !v;
      8: return cy && !z;   9: return !cy || z;   10: return n == v;
      11: return n != v;    12: return !z && n == v;  13: return z || n != v;
      default: return 1'b1;
    endcase
  endfunction
  task automatic ar(input logic sub, input logic [31:0] a, input logic [31:0] b);
    logic [32:0] s;
    logic [3:0]  f;
    s = sub ? {1'b0, a} + {1'b0, ~b} + 33'h1 : {1'b0, a} + {1'b0, b};
    f = {s[31], s[31:0] == 32'h0, s[32], (a[31] == (b[31] ^ sub)) && (s[31] != a[31])};
    bus(1'b1, OFS_OPA, a);
    bus(1'b1, OFS_OPB, b);
    bus(1'b0, OFS_RESULT, 32'h0);
    prev = q;
    bus(1'b1, OFS_FLAGS, {28'h0, ~f});
    exec(sub ? 32'h5 : 32'h6);
    bus(1'b0, OFS_RESULT, 32'h0);
    `CHK({q, flags}, {prev, f})
    exec(sub ? 32'h4 : 32'h3);
    bus(1'b0, OFS_RESULT, 32'h0);
    `CHK({q, flags}, {s[31:0], f})
  endtask
  // x = {access made, range refused, fault raised}; flags checked to still read 5
  task automatic mop(input logic [12:0] c, input logic [31:0] a, b, input logic [2:0] x);
    int f0, a0;
    bus(1'b1, OFS_OPA, a);
    bus(1'b1, OFS_OPB, b);
    f0 = nflt;
    a0 = nacc;
    exec({19'h0, c});
    `CHK({nacc != a0, q[STAT_RANGE], q[STAT_FAULT], nflt != f0}, {x, x[0]})
    `CHK(flags, 4'h5)
  endtask
  task automatic ld(input logic [12:0] c, input logic [31:0] a, b, x);
    mop(c, a, b, 3'b100);
    bus(1'b0, OFS_RESULT, 32'h0);
    `CHK(q, x)
  endtask
  // ==========================================================
  // main sequence
  initial begin
    {arst_n, rd_q, wr_q, adr, wdat, mdly, cyc, nflt, nacc} = '0;
    repeat (12) @(posedge clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge clk);
    `CHK(flags, FLAGS_RST)
    bus(1'b1, 8'h40, 32'hFFFF_FFFF);
    bus(1'b0, 8'h40, 32'h0);
    `CHK(q, WORD_RST)
    bus(1'b1, OFS_OPA, SRC);
    foreach (rl[i]) begin
      k = rl[i] % 32;
      e = 32'({SRC, SRC} >> k);
      bus(1'b1, OFS_OPB, 32'(rl[i]));
      bus(1'b1, OFS_FLAGS, 32'h0000_000F);
      exec(32'h1);
      bus(1'b0, OFS_RESULT, 32'h0);
      `CHK({q, flags}, {e, 4'hF})
      exec(32'h2);
      bus(1'b0, OFS_RESULT, 32'h0);
      `CHK({q, flags}, {e, e[31], e == 32'h0, SRC[(rl[i] - 1) % 32], 1'b1})
    end
    ar(1'b0, 32'hFFFF_FFFF, 32'h0000_0001);
    ar(1'b0, 32'h7FFF_FFFF, 32'h0000_0001);
    ar(1'b0, 32'h8000_0000, 32'h8000_0000);
    ar(1'b1, 32'h0000_0005, 32'h0000_0005);
    ar(1'b1, 32'h8000_0000, 32'h0000_0001);
    ar(1'b1, 32'h0000_0001, 32'h0000_0002);
    bus(1'b1, OFS_OPA, 32'h0000_0200);
    bus(1'b1, OFS_OPB, 32'h0000_0010);
    for (int f = 0; f < 16; f++) begin
      for (int c = 0; c < 15; c++) begin
        bus(1'b1, OFS_FLAGS, 32'(f));
        exec(32'(c * 16 + 7));
        `CHK({q[STAT_TAKEN], flags}, {cond_ok(c, 4'(f)), 4'(f)})
        bus(1'b0, OFS_RESULT, 32'h0);
        if (cond_ok(c, 4'(f))) `CHK(q, 32'h0000_0214)
      end
    end
    bus(1'b1, OFS_FLAGS, 32'h0000_0005);
    bus(1'b1, OFS_OPA, 32'h0000_0100);
    bus(1'b1, OFS_OPB, 32'h0000_03FC);
    exec(32'h8);
    bus(1'b0, OFS_RESULT, 32'h0);
    `CHK({q, flags}, {32'h0000_0500, 4'h5})
    bus(1'b1, OFS_OPB, 32'h0000_0400);
    exec(32'h8);
    `CHK(q[STAT_RANGE], 1'b1)
    mdly <= 4'h6;
    bus(1'b1, OFS_XFER, 32'h8899_AABB);
    mop(13'h020A, 32'h20, 32'h4, 3'b100);
    `CHK(last, {32'h0000_0024, 32'h8899_AABB, 4'hF, 1'b1})
    bus(1'b1, OFS_XFER, 32'h1234_56C3);
    mop(13'h000A, 32'h20, 32'h5, 3'b100);
    `CHK(last, {32'h0000_0025, 32'hC3C3_C3C3, 4'h2, 1'b1})
    bus(1'b1, OFS_XFER, 32'h5678_D00D);
    mop(13'h010A, 32'h20, 32'h6, 3'b100);
    `CHK(last, {32'h0000_0026, 32'hD00D_D00D, 4'hC, 1'b1})
    mdly <= 4'h0;
    ld(13'h0209, 32'h20, 32'h4, 32'hD00D_C3BB);
    ld(13'h0009, 32'h20, 32'h5, 32'h0000_00C3);
    ld(13'h0109, 32'h20, 32'h6, 32'h0000_D00D);
    ld(13'h1509, 32'h6, 32'h20, 32'hFFFF_D00D);
    ld(13'h1409, 32'h5, 32'h20, 32'hFFFF_FFC3);
    mop(13'h0009, 32'h20, 32'd32, 3'b010);
    mop(13'h0209, 32'h20, 32'h80, 3'b010);
    mop(13'h0A09, 32'h20, 32'h80, 3'b100);
    mop(13'h0A09, 32'h0, 32'h400, 3'b010);
    mop(13'h0109, 32'h20, 32'h40, 3'b010);
    mop(13'h0209, 32'h22, 32'h0, 3'b001);
    mop(13'h010A, 32'h21, 32'h2, 3'b001);
    mop(13'h0009, 32'h23, 32'h0, 3'b100);
    mop(13'h1209, 32'h21, 32'h1, 3'b001);
    mop(13'h1209, 32'h23, 32'h1, 3'b100);
    give_verdict();
  end
endmodule

// *** verilog/cfu_pkg.sv ***
package cfu_pkg;
  // ==========================================================
  // register map (byte addresses, one word each)
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_OPA    = 8'h04;
  localparam logic [7:0] OFS_OPB    = 8'h08;
  localparam logic [7:0] OFS_XFER   = 8'h0C;
  localparam logic [7:0] OFS_RESULT = 8'h10;
  localparam logic [7:0] OFS_FLAGS  = 8'h14;
  localparam logic [7:0] OFS_STATUS = 8'h18;
  // ==========================================================
  // control word fields
  localparam int CTRL_OP_LSB    = 0;
  localparam int CTRL_COND_LSB  = 4;
  localparam int CTRL_SIZE_LSB  = 8;
  localparam int CTRL_SIGN_BIT  = 10;
  localparam int CTRL_STACK_BIT = 11;
  localparam int CTRL_ROFS_BIT  = 12;
  // ==========================================================
  // flag and status bit positions
  localparam int FLAG_N = 3;
  localparam int FLAG_Z = 2;
  localparam int FLAG_C = 1;
  localparam int FLAG_V = 0;
  localparam int STAT_BUSY  = 0;
  localparam int STAT_FAULT = 1;
  localparam int STAT_TAKEN = 2;
  localparam int STAT_RANGE = 3;
  localparam logic [3:0]  FLAGS_RST  = 4'h0;
  localparam logic [31:0] WORD_RST   = 32'h0000_0000;
  // ==========================================================
  // immediate limits and program counter lead
  localparam logic [31:0] IMM_STACK_WORD_MAX = 32'h0000_03FC;
  localparam logic [31:0] IMM_LOW_WORD_MAX   = 32'h0000_007C;
  localparam logic [31:0] IMM_HALF_MAX       = 32'h0000_003E;
  localparam logic [31:0] IMM_BYTE_MAX       = 32'h0000_001F;
  localparam logic [31:0] ADDR_GEN_MAX       = 32'h0000_03FC;
  localparam logic [31:0] PROGRAM_COUNTER_AHEAD = 32'h0000_0004;
  // ==========================================================
  typedef enum logic [3:0] {
    OP_NOP, OP_ROTATE_RIGHT, OP_ROTATE_RIGHT_SETF, OP_ADD_SETF,
    OP_SUB_SETF, OP_COMPARE_SUB, OP_COMPARE_ADD, OP_BRANCH,
    OP_ADDR_GEN, OP_LOAD, OP_STORE
  } cfu_op_t;
  typedef enum logic [3:0] {
    COND_EQUAL, COND_NOT_EQUAL, COND_CARRY_SET, COND_CARRY_CLEAR,
    COND_MINUS, COND_PLUS, COND_OVERFLOW, COND_NO_OVERFLOW,
    COND_UNSIGNED_HIGHER, COND_LOWER_OR_SAME, COND_SIGNED_GE_T,
    COND_SIGNED_LT_T, COND_SIGNED_GT_T, COND_SIGNED_LE_T, COND_ALWAYS
  } cfu_cond_t;
  typedef enum logic [1:0] {SZ_BYTE, SZ_HALF, SZ_WORD} cfu_size_t;
  typedef enum logic {ST_IDLE, ST_MEM} cfu_state_t;
  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] wdata;
    logic [3:0]  be;
    logic        we;
  } cfu_mem_req_t;
endpackage

// *** verilog/cfu_top.sv ***
// Operation
// - rotate right moves upper bits down, low n bits into the top
// - flag-setting rotate loads carry with source bit n-1
// - rotate by 32 returns source unchanged, carry takes bit 31
// - rotate by n above 32 equals rotate by n-32
// - word aligned on word address, halfword on even, bytes always
// - unaligned load or store raises the fatal fault, no access made
// - program counter for relative addressing is instruction address plus four
// - flags not updated by an operation keep their value
// - negative follows result sign, zero set on zero result
// - carry from add overflow past 32 bits, no borrow, or shift out
// - overflow when bit 31 differs from infinite precision sign
// - compares set flags as subtract or add, result discarded
// - branch taken only when flags meet its condition
// - single-flag conditions test one flag for one or zero
// - compound conditions combine carry, zero, negative and overflow
// - always condition holds whatever the flags
// - address generation adds immediate to counter, aligned, within 1020
// - byte and halfword immediate loads zero-extend, words load whole
// - stores write word, low byte or low halfword at base plus immediate
// - immediate offsets limited per size and base kind
// - address generation and loads and stores keep flags
// - register-offset address is base plus offset register
// - register-offset byte and halfword loads may sign-extend
//
// Our own choices: register access over Avalon-MM and the register offsets.
`timescale 1ns/1ps
module cfu_top (
  input  logic                  i_clk_sys,
  input  logic                  i_arst_n,
  input  logic [7:0]            i_avs_address,
  input  logic                  i_avs_read,
  input  logic                  i_avs_write,
  input  logic [31:0]           i_avs_writedata,
  input  logic [3:0]            i_avs_byteenable,
  output logic [31:0]           o_avs_readdata,
  output logic                  o_avs_waitrequest,
  output logic                  o_mem_valid,
  output cfu_pkg::cfu_mem_req_t o_mem,
  input  logic                  i_mem_ack,
  input  logic [31:0]           i_mem_rdata,
  output logic                  o_fatal_fault,
  output logic [3:0]            o_flags
);
  import cfu_pkg::*;

  // ==========================================================
  // reset release
  logic rst_meta;
  logic rst_n;
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!rst_n);

  // ==========================================================
  // helpers
  function automatic logic [31:0] rotr(input logic [31:0] a, input logic [4:0] m);
    rotr = (a >> m) | (a << (6'd32 - {1'b0, m}));
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] d,
                                        input logic [3:0] be);
    merge = o;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        merge[i*8 +: 8] = d[i*8 +: 8];
      end
    end
  endfunction

  function automatic logic cond_met(input cfu_cond_t c, input logic [3:0] f);
    logic n;
    logic z;
    logic cy;
    logic v;
    n  = f[FLAG_N];
    z  = f[FLAG_Z];
    cy = f[FLAG_C];
    v  = f[FLAG_V];
    case (c)
      COND_EQUAL:           cond_met = z;
      COND_NOT_EQUAL:       cond_met = !z;
      COND_CARRY_SET:       cond_met = cy;
      COND_CARRY_CLEAR:     cond_met = !cy;
      COND_MINUS:           cond_met = n;
      COND_PLUS:            cond_met = !n;
      COND_OVERFLOW:        cond_met = v;
      COND_NO_OVERFLOW:     cond_met = !v;
      COND_UNSIGNED_HIGHER: cond_met = cy && !z;
      COND_LOWER_OR_SAME:   cond_met = !cy || z;
      COND_SIGNED_GE_T:     cond_met = (n == v);
      COND_SIGNED_LT_T:     cond_met = (n != v);
      COND_SIGNED_GT_T:     cond_met = !z && (n == v);
      COND_SIGNED_LE_T:     cond_met = z || (n != v);
      COND_ALWAYS:          cond_met = 1'b1;
      default:              cond_met = 1'b0;
    endcase
  endfunction

  // ==========================================================
  // avalon slave handshake: one wait cycle, answer on the second edge
  logic       wait_reg;
  logic       req;
  logic       acc_wr;
  logic       start;
  cfu_state_t state_reg;
  assign req    = i_avs_read || i_avs_write;
  assign acc_wr = i_avs_write && !wait_reg;
  assign start  = acc_wr && (i_avs_address == OFS_CTRL) && (state_reg == ST_IDLE);

  always_ff @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wait_reg <= 1'b1;
    end else begin
      wait_reg <= !(req && wait_reg);
    end
  end
  assign o_avs_waitrequest = wait_reg;

  // ==========================================================
  // operand registers
  logic [31:0] opa_reg;
  logic [31:0] opb_reg;
  logic [31:0] xfer_reg;
  logic [31:0] res_reg;
  logic [3:0]  flags_reg;
  logic [3:0]  stat_reg;
  always_ff @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      opa_reg  <= WORD_RST;
      opb_reg  <= WORD_RST;
      xfer_reg <= WORD_RST;
    end else if (acc_wr) begin
      if (i_avs_address == OFS_OPA) begin
        opa_reg <= merge(opa_reg, i_avs_writedata, i_avs_byteenable);
      end
      if (i_avs_address == OFS_OPB) begin
        opb_reg <= merge(opb_reg, i_avs_writedata, i_avs_byteenable);
      end
      if (i_avs_address == OFS_XFER) begin
        xfer_reg <= merge(xfer_reg, i_avs_writedata, i_avs_byteenable);
      end
    end
  end

  // read data is ready at the edge where waitrequest drops
  always_ff @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      o_avs_readdata <= WORD_RST;
    end else if (i_avs_read && wait_reg) begin
      case (i_avs_address)
        OFS_OPA:    o_avs_readdata <= opa_reg;
        OFS_OPB:    o_avs_readdata <= opb_reg;
        OFS_XFER:   o_avs_readdata <= xfer_reg;
        OFS_RESULT: o_avs_readdata <= res_reg;
        OFS_FLAGS:  o_avs_readdata <= {28'h000_0000, flags_reg};
        OFS_STATUS: o_avs_readdata <= {28'h000_0000, stat_reg};
        default:    o_avs_readdata <= WORD_RST;
      endcase
    end
  end

  // ==========================================================
  // execute: decoded from the control write itself
  cfu_op_t      op;
  cfu_cond_t    cond;
  cfu_size_t    size;
  logic         sgn;
  logic         stk;
  logic         rofs;
  logic [32:0]  sum33;
  logic [32:0]  dif33;
  logic [31:0]  x_res;
  logic [3:0]   x_flags;
  logic         x_wres;
  logic         x_taken;
  logic         x_range;
  logic         x_fault;
  logic         x_mem;
  cfu_mem_req_t x_req;

  assign sum33 = {1'b0, opa_reg} + {1'b0, opb_reg};
  assign dif33 = {1'b0, opa_reg} + {1'b0, ~opb_reg} + 33'h0_0000_0001;

  always_comb begin
    op      = cfu_op_t'(i_avs_writedata[CTRL_OP_LSB +: 4]);
    cond    = cfu_cond_t'(i_avs_writedata[CTRL_COND_LSB +: 4]);
    size    = cfu_size_t'(i_avs_writedata[CTRL_SIZE_LSB +: 2]);
    sgn     = i_avs_writedata[CTRL_SIGN_BIT];
    stk     = i_avs_writedata[CTRL_STACK_BIT];
    rofs    = i_avs_writedata[CTRL_ROFS_BIT];
    x_res   = res_reg;
    x_flags = flags_reg;
    x_wres  = 1'b0;
    x_taken = 1'b0;
    x_range = 1'b0;
    x_fault = 1'b0;
    x_mem   = 1'b0;
    x_req.addr  = opa_reg + opb_reg;
    x_req.we    = (op == OP_STORE);
    x_req.be    = 4'hF;
    x_req.wdata = xfer_reg;
    case (op)
      OP_ROTATE_RIGHT, OP_ROTATE_RIGHT_SETF: begin
        // lengths past 32 fold by dropping multiples of 32
        x_res  = rotr(opa_reg, opb_reg[4:0]);
        x_wres = 1'b1;
        if (op == OP_ROTATE_RIGHT_SETF) begin
          x_flags[FLAG_N] = x_res[31];
          x_flags[FLAG_Z] = (x_res == WORD_RST);
          if (opb_reg[7:0] != 8'h00) begin
            x_flags[FLAG_C] = x_res[31];
          end
        end
      end
      OP_ADD_SETF, OP_COMPARE_ADD: begin
        x_res  = sum33[31:0];
        x_wres = (op == OP_ADD_SETF);
        x_flags[FLAG_N] = sum33[31];
        x_flags[FLAG_Z] = (sum33[31:0] == WORD_RST);
        x_flags[FLAG_C] = sum33[32];
        x_flags[FLAG_V] = (opa_reg[31] == opb_reg[31])
                          && (sum33[31] != opa_reg[31]);
      end
      OP_SUB_SETF, OP_COMPARE_SUB: begin
        x_res  = dif33[31:0];
        x_wres = (op == OP_SUB_SETF);
        x_flags[FLAG_N] = dif33[31];
        x_flags[FLAG_Z] = (dif33[31:0] == WORD_RST);
        x_flags[FLAG_C] = dif33[32];
        x_flags[FLAG_V] = (opa_reg[31] != opb_reg[31])
                          && (dif33[31] != opa_reg[31]);
      end
      OP_BRANCH: begin
        x_taken = cond_met(cond, flags_reg);
        x_res   = opa_reg + PROGRAM_COUNTER_AHEAD + opb_reg;
        x_wres  = x_taken;
      end
      OP_ADDR_GEN: begin
        x_res   = opa_reg + PROGRAM_COUNTER_AHEAD + opb_reg;
        x_range = (opb_reg > ADDR_GEN_MAX) || (x_res[1:0] != 2'h0);
        x_wres  = !x_range;
      end
      OP_LOAD, OP_STORE: begin
        if (!rofs) begin
          case (size)
            SZ_WORD: x_range = (opb_reg[1:0] != 2'h0) ||
                       (opb_reg > (stk ? IMM_STACK_WORD_MAX : IMM_LOW_WORD_MAX));
            SZ_HALF: x_range = opb_reg[0] || (opb_reg > IMM_HALF_MAX);
            SZ_BYTE: x_range = (opb_reg > IMM_BYTE_MAX);
            default: x_range = 1'b1;
          endcase
        end else begin
          x_range = (size != SZ_WORD) && (size != SZ_HALF) && (size != SZ_BYTE);
        end
        // checked on the summed address, never on the base alone
        case (size)
          SZ_WORD: x_fault = (x_req.addr[1:0] != 2'h0);
          SZ_HALF: x_fault = x_req.addr[0];
          default: x_fault = 1'b0;
        endcase
        x_fault = x_fault && !x_range;
        x_mem   = !x_range && !x_fault;
        case (size)
          SZ_BYTE: begin
            x_req.be    = 4'h1 << x_req.addr[1:0];
            x_req.wdata = {4{xfer_reg[7:0]}};
          end
          SZ_HALF: begin
            x_req.be    = x_req.addr[1] ? 4'hC : 4'h3;
            x_req.wdata = {2{xfer_reg[15:0]}};
          end
          default: begin
            x_req.be    = 4'hF;
            x_req.wdata = xfer_reg;
          end
        endcase
      end
      default: begin
        x_res = res_reg;
      end
    endcase
  end

  // ==========================================================
  // flags: software may also load them directly
  always_ff @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      flags_reg <= FLAGS_RST;
    end else if (start) begin
      flags_reg <= x_flags;
    end else if (acc_wr && (i_avs_address == OFS_FLAGS)) begin
      if (i_avs_byteenable[0]) begin
        flags_reg <= i_avs_writedata[3:0];
      end
    end
  end
  assign o_flags = flags_reg;

  // ==========================================================
  // memory access sequence
  cfu_size_t   mem_size_reg;
  logic        mem_sign_reg;
  logic [31:0] lane;
  logic [31:0] ld_val;
  assign lane = i_mem_rdata >> {o_mem.addr[1:0], 3'h0};
  always_comb begin
    case (mem_size_reg)
      SZ_BYTE: ld_val = {{24{mem_sign_reg & lane[7]}}, lane[7:0]};
      SZ_HALF: ld_val = {{16{mem_sign_reg & lane[15]}}, lane[15:0]};
      default: ld_val = i_mem_rdata;
    endcase
  end

  always_ff @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_reg    <= ST_IDLE;
      o_mem_valid  <= 1'b0;
      o_mem        <= '0;
      mem_size_reg <= SZ_WORD;
      mem_sign_reg <= 1'b0;
    end else begin
      unique case (state_reg)
        ST_IDLE: begin
          if (start && x_mem) begin
            state_reg    <= ST_MEM;
            o_mem_valid  <= 1'b1;
            o_mem        <= x_req;
            mem_size_reg <= size;
            mem_sign_reg <= sgn && rofs;
          end
        end
        ST_MEM: begin
          if (i_mem_ack) begin
            state_reg   <= ST_IDLE;
            o_mem_valid <= 1'b0;
          end
        end
      endcase
    end
  end

  // ==========================================================
  // result and status
  always_ff @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      res_reg <= WORD_RST;
    end else if (start && x_wres) begin
      res_reg <= x_res;
    end else if ((state_reg == ST_MEM) && i_mem_ack && !o_mem.we) begin
      res_reg <= ld_val;
    end
  end

  // status is refreshed by every new operation
  always_ff @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      stat_reg      <= 4'h0;
      o_fatal_fault <= 1'b0;
    end else begin
      o_fatal_fault <= start && x_fault;
      stat_reg[STAT_BUSY] <= (start && x_mem) ||
                             ((state_reg == ST_MEM) && !i_mem_ack);
      if (start) begin
        stat_reg[STAT_FAULT] <= x_fault;
        stat_reg[STAT_TAKEN] <= x_taken;
        stat_reg[STAT_RANGE] <= x_range;
      end
    end
  end

  // ==========================================================
  // checks
  logic [31:0] ror_wrap_ref;
  assign ror_wrap_ref = rotr(opa_reg, 5'(opb_reg[7:0] - 8'h20));
  cfu_op_t wr_op;
  assign wr_op = cfu_op_t'(i_avs_writedata[3:0]);

  a_rotate_carry: assert property (
    start && wr_op == OP_ROTATE_RIGHT_SETF && opb_reg[7:0] != 8'h00
    |=> flags_reg[FLAG_C] == res_reg[31] && res_reg == rotr($past(opa_reg), $past(opb_reg[4:0])))
    else $error("rotate carry not last bit out");
  a_rotate_full: assert property (
    start && wr_op == OP_ROTATE_RIGHT && opb_reg[7:0] == 8'h20 |=> res_reg == $past(opa_reg))
    else $error("rotate by 32 changed the value");
  a_rotate_wrap: assert property (
    start && wr_op == OP_ROTATE_RIGHT && opb_reg[7:0] > 8'h20 |=> res_reg == $past(ror_wrap_ref))
    else $error("rotate above 32 differs from n-32");
  a_fault_no_access: assert property (
    start && x_fault |=> o_fatal_fault && !o_mem_valid ##1 !o_fatal_fault)
    else $error("unaligned access not faulted");
  a_aligned_issue: assert property (
    $rose(o_mem_valid) |-> (o_mem.be == 4'hF) ? o_mem.addr[1:0] == 2'h0
    : (!o_mem.addr[0] || (o_mem.be != 4'h3 && o_mem.be != 4'hC)))
    else $error("misaligned access issued");
  a_flags_kept: assert property (
    start && (wr_op == OP_LOAD || wr_op == OP_STORE || wr_op == OP_ADDR_GEN) |=> $stable(flags_reg))
    else $error("memory or address op changed flags");
  a_compare_discard: assert property (
    start && (wr_op == OP_COMPARE_SUB || wr_op == OP_COMPARE_ADD) |=> $stable(res_reg))
    else $error("compare wrote a result");
  a_zero_neg_flags: assert property (
    start && (wr_op == OP_ADD_SETF || wr_op == OP_SUB_SETF)
    |=> flags_reg[FLAG_Z] == (res_reg == WORD_RST) && flags_reg[FLAG_N] == res_reg[31])
    else $error("negative or zero flag wrong");
  a_addr_lead: assert property (
    start && wr_op == OP_ADDR_GEN && !x_range
    |=> res_reg == $past(opa_reg) + PROGRAM_COUNTER_AHEAD + $past(opb_reg))
    else $error("relative address lead wrong");
  a_bus_answer: assert property (
    req && wait_reg |=> !o_avs_waitrequest ##1 o_avs_waitrequest)
    else $error("bus answer not in one cycle");

  c_rotate_set: cover property (start && wr_op == OP_ROTATE_RIGHT_SETF);
  c_fault: cover property (o_fatal_fault);
  c_load_done: cover property (state_reg == ST_MEM && i_mem_ack && !o_mem.we);
  c_branch_taken: cover property (start && wr_op == OP_BRANCH && x_taken);
endmodule
